/* File: hdl/pcs_regs_pkg.sv */
// constants, field positions and carrier types for the coding sublayer
// register pair of one port; shared by the register bank and its timer.
package pcs_regs_pkg;
    // management register addresses
    localparam logic [4:0] ADDR_ERR_COUNT = 5'h15;
    localparam logic [4:0] ADDR_CFG = 5'h16;
    // field positions in the configuration word
    localparam int BIT_FREE_CLK = 11;
    localparam int BIT_QUIET_TX = 10;
    localparam int BIT_FORCE_SD = 9;
    localparam int BIT_DETECT_ALGORITHM_BIT = 8;
    localparam int BIT_DESCRAMBLER_TIMEOUT_SELECT = 7;
    localparam int BIT_FIBER = 6;
    localparam int BIT_GOOD_LINK = 5;
    localparam int BIT_FAR_FAULT = 3;
    // writable bits; 15:12, 4 and 2:0 stay zero
    localparam logic [15:0] CFG_RW_MASK = 16'h0FE8;
    localparam logic [15:0] CFG_RESET = 16'h0100;
    localparam logic [15:0] ERR_RESET = 16'h0000;
    localparam logic [7:0] ERR_MAX = 8'hFF;
    localparam logic [7:0] ERR_ONE = 8'h01;
    localparam logic [7:0] ERR_ZERO = 8'h00;
    // descrambler timeouts and the clock period
    localparam int CLK_PERIOD_NS = 20;
    localparam int DESC_SHORT_US = 722;
    localparam int DESC_LONG_MS = 2;
    localparam int DESC_SHORT_CYCLES = (DESC_SHORT_US * 1000) / CLK_PERIOD_NS;
    localparam int DESC_LONG_CYCLES = (DESC_LONG_MS * 1000000) / CLK_PERIOD_NS;
    localparam int TIMER_W = 17;
    // one management access, as handed over by the frame decoder
    typedef struct packed {
        logic valid;
        logic write;
        logic [4:0] addr;
        logic [15:0] wdata;
    } mgmt_req_t;
    // receive-side symbol events
    typedef struct packed {
        logic carrier;
        logic symbol_error;
        logic collision;
    } rx_event_t;
endpackage

/* File: hdl/desc_lock_timer.sv */
// descrambler lock holder with selectable synchronisation timeout.
// assumes idle and lock pulses are synchronous to ref_clk_in.
`timescale 1ns/1ps
module desc_lock_timer
    import pcs_regs_pkg::*;
#(
    parameter int SHORT_CYCLES = DESC_SHORT_CYCLES,
    parameter int LONG_CYCLES = DESC_LONG_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic long_sel_in,
    input wire logic lock_acquired_in,
    input wire logic idle_seen_in,
    output logic locked_out
);
    // cycles since the last idle refresh
    logic [TIMER_W-1:0] timer;
    // chosen limit for this cycle
    logic [TIMER_W-1:0] limit;

    // pick the timeout from the configuration bit
    always_comb begin
        if (long_sel_in) begin
            limit = TIMER_W'(LONG_CYCLES);
        end else begin
            limit = TIMER_W'(SHORT_CYCLES);
        end
    end

    // timer restarts on every idle or fresh lock
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            timer <= '0;
        end else if (idle_seen_in || lock_acquired_in || !locked_out) begin
            timer <= '0;
        end else if (timer < limit) begin
            timer <= timer + TIMER_W'(1);
        end
    end

    // lock holds until the timer runs out
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            locked_out <= 1'b0;
        end else if (lock_acquired_in) begin
            locked_out <= 1'b1;
        end else if (timer >= limit) begin
            locked_out <= 1'b0;
        end
    end
endmodule

/* File: hdl/pcs_error_counter_config.sv */
// receive symbol error tally and 100 Mb/s coding sublayer configuration
// word for one port, reached through the management register port.
// assumes all inputs are synchronous to ref_clk_in and that the fiber
// strap is stable while reset is released.
`timescale 1ns/1ps
module pcs_error_counter_config
    import pcs_regs_pkg::*;
#(
    parameter int SHORT_CYCLES = DESC_SHORT_CYCLES,
    parameter int LONG_CYCLES = DESC_LONG_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic fiber_strap_in,
    input wire mgmt_req_t mgmt_req_in,
    input wire rx_event_t rx_event_in,
    input wire logic signal_level_in,
    input wire logic lock_acquired_in,
    input wire logic idle_seen_in,
    output logic mgmt_ack_out,
    output logic [15:0] mgmt_rdata_out,
    output logic free_clk_out,
    output logic quiet_tx_out,
    output logic forced_detect_out,
    output logic long_timeout_out,
    output logic fiber_mode_out,
    output logic far_end_fault_out,
    output logic link_up_out
);
    // error tally, low byte of the counter register
    logic [7:0] symbol_error_tally;
    // stored configuration word, only writable bits kept
    logic [15:0] cfg_word;
    // strap has been sampled since reset release
    logic strap_loaded;
    // carrier seen on the previous cycle
    logic carrier_d;
    // an invalid symbol has been seen in this event
    logic err_seen;
    // a collision has been seen in this event
    logic col_seen;
    // raw link state before the override
    logic link_raw;
    // descrambler lock from the timeout holder
    logic desc_locked;
    // decoded accesses
    logic rd_err;
    logic wr_cfg;
    // the carrier event just ended
    logic event_end;
    // the ending event earns one count
    logic bump;
    // qualified signal detect
    logic sig_ok;
    // next values
    logic [7:0] next_tally;
    logic next_link;
    logic [15:0] next_rdata;

    // saturating add of one
    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        if (v == ERR_MAX) begin
            return v;
        end
        return v + ERR_ONE;
    endfunction

    // address decode of the management request
    always_comb begin
        rd_err = 1'b0;
        wr_cfg = 1'b0;
        if (mgmt_req_in.valid && !mgmt_req_in.write) begin
            // only the counter has a read side effect
            rd_err = (mgmt_req_in.addr == ADDR_ERR_COUNT);
        end else if (mgmt_req_in.valid && mgmt_req_in.write) begin
            // counter writes fall through and are ignored
            wr_cfg = (mgmt_req_in.addr == ADDR_CFG);
        end
    end

    // carrier event tracking flags
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            carrier_d <= 1'b0;
        end else begin
            carrier_d <= rx_event_in.carrier;
        end
    end

    // remember errors and collisions inside one event
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            err_seen <= 1'b0;
            col_seen <= 1'b0;
        end else if (!rx_event_in.carrier) begin
            // outside carrier the flags are cleared
            err_seen <= 1'b0;
            col_seen <= 1'b0;
        end else begin
            // sticky within the event
            if (rx_event_in.symbol_error) begin
                err_seen <= 1'b1;
            end
            if (rx_event_in.collision) begin
                col_seen <= 1'b1;
            end
        end
    end

    // decide the count at the end of each carrier event
    always_comb begin
        event_end = carrier_d && !rx_event_in.carrier;
        // one count per event, none with collision
        bump = event_end && err_seen && !col_seen;
    end

    // next tally: read clears, an event in the same cycle survives
    always_comb begin
        next_tally = symbol_error_tally;
        if (rd_err && bump) begin
            // set wins over the read clear
            next_tally = ERR_ONE;
        end else if (rd_err) begin
            next_tally = ERR_ZERO;
        end else if (bump) begin
            // holds at the top
            next_tally = sat_inc(symbol_error_tally);
        end
    end

    // error tally register
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            symbol_error_tally <= ERR_ZERO;
        end else begin
            symbol_error_tally <= next_tally;
        end
    end

    // strap capture happens once, on the first edge after release
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            strap_loaded <= 1'b0;
        end else begin
            strap_loaded <= 1'b1;
        end
    end

    // configuration word: reset, strap load, then software writes
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cfg_word <= CFG_RESET;
        end else if (!strap_loaded) begin
            // fiber and far-end fault default from the strap
            cfg_word[BIT_FIBER] <= fiber_strap_in;
            cfg_word[BIT_FAR_FAULT] <= fiber_strap_in;
        end else if (wr_cfg) begin
            // masked write keeps unused bits at zero
            cfg_word <= mgmt_req_in.wdata & CFG_RW_MASK;
        end
    end

    // read data mux; unused upper bits are zero
    always_comb begin
        next_rdata = '0;
        if (mgmt_req_in.addr == ADDR_ERR_COUNT) begin
            // current value before the clear
            next_rdata = {8'h00, symbol_error_tally};
        end else if (mgmt_req_in.addr == ADDR_CFG) begin
            next_rdata = cfg_word & CFG_RW_MASK;
        end
    end

    // management answer, one cycle after the request
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mgmt_ack_out <= 1'b0;
            mgmt_rdata_out <= ERR_RESET;
        end else begin
            mgmt_ack_out <= mgmt_req_in.valid;
            if (mgmt_req_in.valid && !mgmt_req_in.write) begin
                mgmt_rdata_out <= next_rdata;
            end
        end
    end

    // configuration outputs straight from the stored word
    always_comb begin
        // free-running receive clock when set
        free_clk_out = cfg_word[BIT_FREE_CLK];
        // true quiet transmit when set
        quiet_tx_out = cfg_word[BIT_QUIET_TX];
        // signal detect forced on
        forced_detect_out = cfg_word[BIT_FORCE_SD];
        // long descrambler timeout
        long_timeout_out = cfg_word[BIT_DESCRAMBLER_TIMEOUT_SELECT];
        // fiber operation enable
        fiber_mode_out = cfg_word[BIT_FIBER];
        // far-end fault indication enable
        far_end_fault_out = cfg_word[BIT_FAR_FAULT];
    end

    // descrambler lock holder with the chosen timeout
    desc_lock_timer #(
        .SHORT_CYCLES(SHORT_CYCLES),
        .LONG_CYCLES(LONG_CYCLES)
    ) u_lock (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .long_sel_in(cfg_word[BIT_DESCRAMBLER_TIMEOUT_SELECT]),
        .lock_acquired_in(lock_acquired_in),
        .idle_seen_in(idle_seen_in),
        .locked_out(desc_locked)
    );

    // link state decision by the detect algorithm
    always_comb begin
        // forcing makes signal detect always true
        sig_ok = signal_level_in || cfg_word[BIT_FORCE_SD];
        next_link = link_raw;
        if (!link_raw) begin
            // rise needs valid level and lock in both modes
            next_link = sig_ok && desc_locked;
        end else if (cfg_word[BIT_DETECT_ALGORITHM_BIT]) begin
            // lost lock is tolerated
            next_link = sig_ok;
        end else begin
            // either loss drops the link
            next_link = sig_ok && desc_locked;
        end
    end

    // raw link register
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            link_raw <= 1'b0;
        end else begin
            link_raw <= next_link;
        end
    end

    // reported link, with the good link override
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            link_up_out <= 1'b0;
        end else begin
            // override forces good 100 Mb/s link
            link_up_out <= next_link || cfg_word[BIT_GOOD_LINK];
        end
    end
endmodule

/* File: sim/pcs_cfg_monitor.sv */
// checker for the error tally and configuration word ports
// assumes it is bound onto every pcs_error_counter_config
`timescale 1ns/1ps
module pcs_cfg_monitor
    import pcs_regs_pkg::*;
#(
    parameter int SHORT_CYCLES = DESC_SHORT_CYCLES,
    parameter int LONG_CYCLES = DESC_LONG_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic fiber_strap_in,
    input wire mgmt_req_t mgmt_req_in,
    input wire rx_event_t rx_event_in,
    input wire logic signal_level_in,
    input wire logic lock_acquired_in,
    input wire logic idle_seen_in,
    input wire logic mgmt_ack_out,
    input wire logic [15:0] mgmt_rdata_out,
    input wire logic free_clk_out,
    input wire logic quiet_tx_out,
    input wire logic forced_detect_out,
    input wire logic long_timeout_out,
    input wire logic fiber_mode_out,
    input wire logic far_end_fault_out,
    input wire logic link_up_out
);
    logic wr_cfg; // config write taken this edge
    logic rd_err; // tally read taken this edge
    logic rd_cfg; // config read taken this edge
    logic good_q; // mirror of the good-link override bit
    assign wr_cfg = mgmt_req_in.valid && mgmt_req_in.write && mgmt_req_in.addr == ADDR_CFG;
    assign rd_err = mgmt_req_in.valid && !mgmt_req_in.write && mgmt_req_in.addr == ADDR_ERR_COUNT;
    assign rd_cfg = mgmt_req_in.valid && !mgmt_req_in.write && mgmt_req_in.addr == ADDR_CFG;
    // track the override so link checks know when it is off
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            good_q <= 1'b0;
        end else if (wr_cfg) begin
            good_q <= mgmt_req_in.wdata[BIT_GOOD_LINK];
        end
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    property p_err_hi; rd_err |=> mgmt_rdata_out[15:8] == 8'h00; endproperty
    a_err_hi: assert property (p_err_hi) else $error("tally upper byte set");
    property p_cfg_rsv; rd_cfg |=> (mgmt_rdata_out & ~CFG_RW_MASK) == 16'h0000; endproperty
    a_cfg_rsv: assert property (p_cfg_rsv) else $error("unused config bit set");
    property p_free; wr_cfg |=> free_clk_out == $past(mgmt_req_in.wdata[11]); endproperty
    a_free: assert property (p_free) else $error("free clock bit wrong");
    property p_quiet; wr_cfg |=> quiet_tx_out == $past(mgmt_req_in.wdata[10]); endproperty
    a_quiet: assert property (p_quiet) else $error("quiet transmit bit wrong");
    property p_force; wr_cfg |=> forced_detect_out == $past(mgmt_req_in.wdata[9]); endproperty
    a_force: assert property (p_force) else $error("forced detect bit wrong");
    property p_tmo; wr_cfg |=> long_timeout_out == $past(mgmt_req_in.wdata[7]); endproperty
    a_tmo: assert property (p_tmo) else $error("timeout select wrong");
    property p_far; wr_cfg |=> far_end_fault_out == $past(mgmt_req_in.wdata[3]); endproperty
    a_far: assert property (p_far) else $error("far-end fault bit wrong");
    property p_strap; $rose(reset_n_in) |=> fiber_mode_out == $past(fiber_strap_in); endproperty
    a_strap: assert property (p_strap) else $error("fiber mode not from strap");
    property p_good; wr_cfg && mgmt_req_in.wdata[5] |-> ##[1:2] link_up_out; endproperty
    a_good: assert property (p_good) else $error("forced link not up");
    property p_drop;
        (!signal_level_in && !forced_detect_out && !good_q) [*2] |=> !link_up_out;
    endproperty
    a_drop: assert property (p_drop) else $error("link up without signal");
    c_sat: cover property (rd_err ##1 mgmt_rdata_out[7:0] == ERR_MAX);
    c_wr: cover property (wr_cfg);
    c_fall: cover property ($fell(link_up_out));
endmodule
bind pcs_error_counter_config pcs_cfg_monitor #(
    .SHORT_CYCLES(SHORT_CYCLES),
    .LONG_CYCLES(LONG_CYCLES)
) mon (.*);

/* File: sim/mgmt_host_model.sv */
// station management host issuing one-cycle register requests
// assumes the bank answers one cycle after it takes a request
`timescale 1ns/1ps
module mgmt_host_model
    import pcs_regs_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic mgmt_ack_in,
    input wire logic [15:0] mgmt_rdata_in,
    output mgmt_req_t mgmt_req_out
);
    initial mgmt_req_out = '0;
    // one access; released fields show the inverse of the request
    task automatic xfer(input logic wr, input logic [4:0] a, input logic [15:0] d,
        output logic ack, output logic [15:0] rd);
        @(posedge ref_clk_in);
        #1 mgmt_req_out = '{1'b1, wr, a, d};
        @(posedge ref_clk_in);
        #1 mgmt_req_out = '{1'b0, ~wr, ~a, ~d};
        ack = mgmt_ack_in;
        rd = mgmt_rdata_in;
    endtask
endmodule

/* File: sim/tb.sv */
// self-checking bench for the error tally and configuration word
// assumes the package and host model are compiled before it
`timescale 1ns/1ps
module tb;
    import pcs_regs_pkg::*;
    localparam int SHORT = 20; // shortened timeouts
    localparam int LONG = 50;
    logic ref_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic strap = 1'b1;
    rx_event_t rx = '0;
    logic sig = 1'b0;
    logic lock = 1'b0;
    logic idle = 1'b0;
    mgmt_req_t req;
    wire ack;
    wire [15:0] rdata;
    wire [5:0] cfg_o; // free, quiet, forced, long, fiber, far
    wire link;
    int bad_count = 0;
    int checks = 0;
    logic f;
    logic [15:0] d, rd;
    logic [7:0] exp_cnt;
    always #10 ref_clk_in = ~ref_clk_in;
    mgmt_host_model host (.ref_clk_in(ref_clk_in), .mgmt_ack_in(ack),
        .mgmt_rdata_in(rdata), .mgmt_req_out(req));
    pcs_error_counter_config #(.SHORT_CYCLES(SHORT), .LONG_CYCLES(LONG)) dut (
        .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .fiber_strap_in(strap),
        .mgmt_req_in(req), .rx_event_in(rx), .signal_level_in(sig),
        .lock_acquired_in(lock), .idle_seen_in(idle), .mgmt_ack_out(ack),
        .mgmt_rdata_out(rdata), .free_clk_out(cfg_o[5]), .quiet_tx_out(cfg_o[4]),
        .forced_detect_out(cfg_o[3]), .long_timeout_out(cfg_o[2]),
        .fiber_mode_out(cfg_o[1]), .far_end_fault_out(cfg_o[0]), .link_up_out(link));
    task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk_bits(input logic [5:0] g, input logic [5:0] e);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // expected config outputs for a written word
    function automatic logic [5:0] outs(input logic [15:0] v);
        return {v[11], v[10], v[9], v[7], v[6], v[3]};
    endfunction
    task automatic reg_rd(input logic [4:0] a, input logic [15:0] e);
        host.xfer(1'b0, a, 16'h0000, f, rd);
        chk_bits({5'h00, f}, 6'h01);
        chk_word(rd, e);
    endtask
    task automatic wr(input logic [15:0] v);
        host.xfer(1'b1, ADDR_CFG, v, f, rd);
    endtask
    // one carrier event: two errors inside when err is set, one just after it
    task automatic ev(input logic err, input logic coll);
        @(posedge ref_clk_in) #1 rx = '{1'b1, 1'b0, 1'b0};
        @(posedge ref_clk_in) #1 rx = '{1'b1, err, coll};
        @(posedge ref_clk_in) #1 rx = '{1'b1, err, 1'b0};
        @(posedge ref_clk_in) #1 rx = '{1'b0, 1'b1, 1'b0};
        @(posedge ref_clk_in) #1 rx = '0;
        if (err && !coll && exp_cnt != ERR_MAX) exp_cnt++;
    endtask
    task automatic pulse(input logic is_idle);
        @(posedge ref_clk_in) #1 lock = !is_idle;
        idle = is_idle;
        @(posedge ref_clk_in) #1 lock = 1'b0;
        idle = 1'b0;
    endtask
    task automatic wait_link(input int n, input logic e);
        repeat (n) @(posedge ref_clk_in);
        #1 chk_bits({5'h00, link}, {5'h00, e});
    endtask
    task automatic conclude;
        if (bad_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // watchdog: the sequence needs about 1800 cycles
    initial begin
        #400000;
        bad_count++;
        conclude();
    end
    initial begin
        void'($urandom(88758));
        repeat (5) @(posedge ref_clk_in);
        #1 reset_n_in = 1'b1;
        repeat (2) @(posedge ref_clk_in);
        #1 chk_bits(cfg_o, 6'h03);
        reg_rd(ADDR_CFG, 16'h0148);
        reg_rd(ADDR_ERR_COUNT, ERR_RESET);
        for (int i = 0; i < 24; i++) begin
            d = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($urandom);
            wr(d);
            chk_bits(cfg_o, outs(d));
            reg_rd(ADDR_CFG, d & CFG_RW_MASK);
        end
        host.xfer(1'b1, ADDR_ERR_COUNT, 16'hFFFF, f, rd);
        reg_rd(ADDR_ERR_COUNT, 16'h0000);
        reg_rd(5'h1F, 16'h0000);
        exp_cnt = ERR_ZERO;
        for (int i = 0; i < 40; i++) begin
            ev(1'($urandom), 1'($urandom));
            if (i % 8 == 7) begin
                reg_rd(ADDR_ERR_COUNT, {8'h00, exp_cnt});
                exp_cnt = ERR_ZERO;
            end
        end
        repeat (260) ev(1'b1, 1'b0);
        reg_rd(ADDR_ERR_COUNT, {8'h00, exp_cnt});
        reg_rd(ADDR_ERR_COUNT, 16'h0000);
        wr(16'h0100);
        sig = 1'b1;
        pulse(1'b0);
        wait_link(3, 1'b1);
        wait_link(LONG + 10, 1'b1);
        wr(16'h0000);
        pulse(1'b0);
        repeat (6) pulse(1'b1);
        wait_link(3, 1'b1);
        wait_link(SHORT + 5, 1'b0);
        wr(16'h0080);
        pulse(1'b0);
        wait_link(SHORT + 5, 1'b1);
        wait_link(LONG - SHORT + 5, 1'b0);
        wr(16'h0020);
        sig = 1'b0;
        wait_link(3, 1'b1);
        wr(16'h0100);
        wait_link(3, 1'b0);
        conclude();
    end
endmodule
